// *** design/orf_pkg.sv ***
// Package of constants for the over-range flag and output format block
package orf_pkg;
  localparam int          SAMPLE_W       = 12;
  localparam int          FIFO_DEPTH     = 8;
  localparam int          FIFO_AW        = 3;
  localparam logic [11:0] CODE_OB_POS    = 12'hFFF;
  localparam logic [11:0] CODE_OB_NEG    = 12'h000;
  localparam logic [11:0] CODE_TC_POS    = 12'h7FF;
  localparam logic [11:0] CODE_TC_NEG    = 12'h800;
  localparam logic [11:0] MSB_FLIP       = 12'h800;
  localparam logic        FMT_RST        = 1'b0;
  localparam logic        FMT_OFFSET_BIN = 1'b0;
  localparam logic        FMT_TWOS_COMP  = 1'b1;
endpackage

// *** design/orf_fifo.sv ***
// Parameterised flip-flop FIFO with valid and ready on both sides
`timescale 1ns/10ps
module orf_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

// *** design/orf_top.sv ***
// Over-range flag and output format logic of the converter output side
// Functional notes
// - Flag high when sample beyond full scale
// - Flag stays high while overload persists
// - Flag independent of output interface mode
// - Positive overload gives FFF or 7FF
// - Negative overload gives 000 or 800
// - Format from register bit or pin
// - Twelve-bit word with synchronous output clock
`timescale 1ns/10ps
module orf_top (
  input  wire logic                         clk,
  input  wire logic                         sys_rst,
  input  wire logic                         smp_valid,
  output logic                              smp_ready,
  input  wire logic [orf_pkg::SAMPLE_W-1:0] smp_code,
  input  wire logic                smp_over_pos,
  input  wire logic                smp_over_neg,
  input  wire logic                format_cfg_bit,
  input  wire logic                parallel_cfg_mode,
  input  wire logic                format_select_pin,
  input  wire logic                ddr_mode,
  output logic [orf_pkg::SAMPLE_W-1:0]      out_data,
  output logic                     overrange_flag,
  output logic                     out_valid,
  input  wire logic                out_ready,
  output logic                     out_clk_en
);
  import orf_pkg::*;

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic pin_meta;
  logic pin_sync;
  logic par_meta;
  logic par_sync;
  logic fmt_sel;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_meta <= FMT_RST;
      pin_sync <= FMT_RST;
      par_meta <= 1'b0;
      par_sync <= 1'b0;
    end else begin
      pin_meta <= format_select_pin;
      pin_sync <= pin_meta;
      par_meta <= parallel_cfg_mode;
      par_sync <= par_meta;
    end
  end

  // ************************************************************
  // Format selection and encoding
  // ************************************************************
  logic [SAMPLE_W-1:0] next_code;
  logic                next_ovr;

  assign fmt_sel = par_sync ? pin_sync : format_cfg_bit;

  always_comb begin
    next_ovr  = smp_over_pos || smp_over_neg;
    next_code = smp_code;
    if (smp_over_pos) begin
      next_code = CODE_OB_POS;
    end else if (smp_over_neg) begin
      next_code = CODE_OB_NEG;
    end
    if (fmt_sel == FMT_TWOS_COMP) begin
      next_code = next_code ^ MSB_FLIP;
    end
  end

  // ************************************************************
  // Output buffer
  // ************************************************************
  logic [SAMPLE_W:0] fifo_out;
  logic              fifo_valid;

  orf_fifo #(
    .WIDTH (SAMPLE_W+1),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_valid  (smp_valid),
    .in_ready  (smp_ready),
    .in_data   ({next_ovr, next_code}),
    .out_valid (fifo_valid),
    .out_ready (out_ready),
    .out_data  (fifo_out)
  );

  // ************************************************************
  // Output registers
  // ************************************************************
  // Flag follows every sample, so it stays high across overload runs
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      out_data       <= '0;
      overrange_flag <= 1'b0;
      out_clk_en     <= 1'b0;
    end else begin
      out_clk_en <= fifo_valid && out_ready;
      if (fifo_valid && out_ready) begin
        out_data       <= fifo_out[SAMPLE_W-1:0];
        overrange_flag <= fifo_out[SAMPLE_W];
      end
    end
  end

  assign out_valid = out_clk_en;

  logic unused_ddr;
  assign unused_ddr = ddr_mode;
endmodule

// *** testbench/orf_top_asserts.sv ***
// Checker of the output word, flag and enable
`timescale 1ns/10ps
module orf_top_asserts (
  input wire logic                         clk,
  input wire logic                         sys_rst,
  input wire logic                         smp_valid,
  input wire logic                         smp_ready,
  input wire logic [orf_pkg::SAMPLE_W-1:0] out_data,
  input wire logic                         overrange_flag,
  input wire logic                         out_valid,
  input wire logic                         out_clk_en
);
  import orf_pkg::*;
  int inflight;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_take; smp_valid && smp_ready; endsequence
  sequence s_word; out_valid && out_clk_en; endsequence
  always_ff @(posedge clk)
    inflight <= sys_rst ? 0 : inflight + (smp_valid && smp_ready) - out_valid;
  a_enable_pair: assert property (out_valid == out_clk_en)
    else $error("enable apart from word");
  a_word_follows: assert property (s_take |-> ##[2:60] s_word)
    else $error("word missing");
  a_no_extra: assert property (out_valid |-> inflight > 0)
    else $error("word without sample");
  a_data_stands: assert property ($changed(out_data) |-> out_valid)
    else $error("data moved");
  a_flag_stands: assert property ($changed(overrange_flag) |-> out_valid)
    else $error("flag moved");
  a_over_codes: assert property (out_valid && overrange_flag |->
    out_data inside {12'hFFF, 12'h7FF, 12'h000, 12'h800}) else $error("code");
  a_reset_quiet: assert property (disable iff (1'b0) sys_rst |=>
    !out_valid && !overrange_flag && out_data == 12'h000) else $error("reset");
  a_ready_reset: assert property ($fell(sys_rst) |-> smp_ready)
    else $error("not ready");
endmodule
bind orf_top orf_top_asserts u_orf_top_asserts (.clk, .sys_rst, .smp_valid,
  .smp_ready, .out_data, .overrange_flag, .out_valid, .out_clk_en);

// *** testbench/orf_rx_model.sv ***
// Receiver model taking output words with random stalls
`timescale 1ns/10ps
module orf_rx_model (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic stall,
  output logic      out_ready = 1'b0
);
  always_ff @(posedge clk) begin
    out_ready <= !sys_rst && !stall && $urandom % 4 != 0;
  end
endmodule

// *** testbench/test_orf_top.sv ***
// Self-checking bench of the over-range flag and output format block
`timescale 1ns/10ps
module test_orf_top;
  import orf_pkg::*;
  logic clk = 0, sys_rst = 1, smp_valid = 0, smp_over_pos = 0, smp_over_neg = 0;
  logic format_cfg_bit = 0, parallel_cfg_mode = 0, format_select_pin = 0;
  logic ddr_mode = 0, stall = 0, smp_ready, overrange_flag, out_valid;
  logic out_ready, out_clk_en;
  logic [11:0] smp_code = 0, out_data;
  logic [12:0] exp_q[$];
  int          error_cnt = 0, tests_run = 0;
  always #2.5 clk = ~clk;
  orf_top u_orf_top (.clk, .sys_rst, .smp_valid, .smp_ready, .smp_code,
    .smp_over_pos, .smp_over_neg, .format_cfg_bit, .parallel_cfg_mode,
    .format_select_pin, .ddr_mode, .out_data, .overrange_flag, .out_valid,
    .out_ready, .out_clk_en);
  orf_rx_model u_orf_rx_model (.clk, .sys_rst, .stall, .out_ready);
  task automatic chk(string nm, logic [12:0] seen, logic [12:0] exp);
    tests_run++;
    if (seen !== exp) begin
      $display("unexpected %s exp %h seen %h", nm, exp, seen);
      error_cnt++;
    end
  endtask
  task automatic report_and_stop;
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic send(logic fmt);
    int ov;
    ov = $urandom % 3;
    smp_valid <= 1;
    smp_code <= 12'($urandom);
    smp_over_pos <= ov == 1;
    smp_over_neg <= ov == 2;
    ddr_mode <= 1'($urandom);
    do @(posedge clk); while (smp_ready !== 1'b1);
    exp_q.push_back(ov == 1 ? {1'b1, fmt ? 12'h7FF : 12'hFFF} :
      ov == 2 ? {1'b1, fmt ? 12'h800 : 12'h000} :
      {1'b0, smp_code ^ {fmt, 11'h0}});
  endtask
  always @(posedge clk) begin
    if (out_valid === 1'b1) begin
      chk("enable", out_clk_en, 1);
      chk("word", {overrange_flag, out_data},
        exp_q.size() ? exp_q.pop_front() : 'x);
    end
  end
  initial begin
    void'($urandom(25));
    repeat (8) @(posedge clk);
    sys_rst <= 0;
    for (int ph = 0; ph < 4; ph++) begin
      smp_valid <= 0;
      @(posedge clk);
      format_cfg_bit <= ph[0];
      format_select_pin <= !ph[0];
      parallel_cfg_mode <= ph[1];
      if (ph == 2) fork
        begin stall <= 1; repeat (20) @(posedge clk); stall <= 0; end
      join_none
      repeat (4) @(posedge clk);
      repeat (24) send(ph[1] ^ ph[0]);
    end
    smp_valid <= 0;
    repeat (60) @(posedge clk);
    chk("left", 13'(exp_q.size()), 0);
    report_and_stop();
  end
  initial begin
    #20000;
    error_cnt++;
    report_and_stop();
  end
endmodule
